// ==== src/fadr_defines.svh ====
// Opcodes, field positions, reset values and counts of the flash read path
`ifndef FADR_DEFINES_SVH
`define FADR_DEFINES_SVH
`define FADR_OP_WREN 8'h06
`define FADR_OP_WRDI 8'h04
`define FADR_OP_EN4B 8'hB7
`define FADR_OP_EX4B 8'hE9
`define FADR_OP_RDEXT 8'hC8
`define FADR_OP_WREXT 8'hC5
`define FADR_OP_SETPAR 8'hC0
`define FADR_OP_RSTEN 8'h66
`define FADR_OP_RST 8'h99
`define FADR_OP_READ 8'h03
`define FADR_OP_READ4 8'h13
`define FADR_OP_FAST 8'h0B
`define FADR_OP_FAST4 8'h0C
`define FADR_OP_DUAL 8'h3B
`define FADR_EXT_RST 8'h00
`define FADR_PAR_RST 2'h0
`define FADR_PAR_LSB 4
`define FADR_DUMMY_SPI 4'h8
`define FADR_DUMMY_QPI_MIN 4'h2
`define FADR_ALEN3 6'h18
`define FADR_ALEN4 6'h20
`define FADR_BYTE_BITS 6'h08
`define FADR_FIFO_DEPTH 32
`define FADR_BYTE_W 8
`endif

// ==== src/fadr_fifo.sv ====
// Byte FIFO between array fetch and serial shifter
`timescale 1ns/1ns
`default_nettype none
module fadr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  // Honest flags from the occupancy count
  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // Storage has no reset; only pointers matter
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end

  // Pointers wrap naturally, depth is a power of two
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== src/fadr_pkg.sv ====
// Types shared by the flash read path
package fadr_pkg;
  typedef enum logic [2:0] {
    FADR_ST_CMD,
    FADR_ST_ADDR,
    FADR_ST_DUMMY,
    FADR_ST_OUT,
    FADR_ST_RIN,
    FADR_ST_SKIP
  } fadr_state_t;

  typedef struct packed {
    logic rd;
    logic [31:0] addr;
  } fadr_arr_req_t;
endpackage

// ==== src/fadr_top.sv ====
// Serial flash command decode, address modes and read data path
`timescale 1ns/1ns
`default_nettype none
`include "fadr_defines.svh"
module fadr_top (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  input wire logic four_wire_command_mode_i,
  input wire logic busy_i,
  output logic write_arm_flag_o,
  output logic address_width_flag_o,
  output logic [7:0] ext_addr_o,
  output fadr_pkg::fadr_arr_req_t arr_req_o,
  input wire logic arr_valid_i,
  input wire logic [7:0] arr_data_i
);
  import fadr_pkg::*;

  logic [2:0] sclk_s;
  logic [1:0] csn_s;
  logic [3:0] io_s1, io_s2;
  logic rise, fall, cs_idle, four_wire_command_mode;
  fadr_state_t st_q;
  logic [31:0] sh_q, sh_n, eff_addr;
  logic [5:0] cnt_q, cnt_n, alen_q;
  logic [3:0] dum_q, olw_q, ocnt_q;
  logic osrc_ext_q, tgt_par_q;
  logic wel_q, ads_q, rsten_q;
  logic [7:0] ext_q, opc, obyte_q, src_byte, cur_byte;
  logic [1:0] par_q;
  logic [3:0] io_q, oe_n_q;
  logic cmd_done, addr_done, rin_done, is_read;
  logic fact_q, pend_q;
  logic [31:0] faddr_q;
  fadr_arr_req_t areq_q;
  logic issue, fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;

  // Pin synchronisers; the link clock is sampled, not used as a clock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_s <= 3'h0;
      csn_s <= 2'h3;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk_i};
      csn_s <= {csn_s[0], cs_n_i};
      io_s1 <= io_i;
      io_s2 <= io_s1;
    end
  end

  // Edge detect on the second and third stages only
  assign rise = sclk_s[1] && !sclk_s[2] && !csn_s[1];
  assign fall = !sclk_s[1] && sclk_s[2] && !csn_s[1];
  assign cs_idle = csn_s[1];
  assign four_wire_command_mode = four_wire_command_mode_i;

  // Next shift value: four lanes in four-wire mode, else serial_in_pin on lane zero
  always_comb begin
    if (four_wire_command_mode) begin
      sh_n = {sh_q[27:0], io_s2};
      cnt_n = cnt_q + 6'h04;
    end else begin
      sh_n = {sh_q[30:0], io_s2[0]};
      cnt_n = cnt_q + 6'h01;
    end
  end

  assign opc = sh_n[7:0];
  assign cmd_done = rise && (st_q == FADR_ST_CMD) && (cnt_n == `FADR_BYTE_BITS);
  assign addr_done = rise && (st_q == FADR_ST_ADDR) && (cnt_n == alen_q);
  assign rin_done = rise && (st_q == FADR_ST_RIN) && (cnt_n == `FADR_BYTE_BITS);
  // Short addresses borrow the extended byte as the top byte
  assign eff_addr = (alen_q == `FADR_ALEN4) ? sh_n : {ext_q, sh_n[23:0]};
  assign is_read = !busy_i;

  // Command sequencer, advanced on sampled rising link edges
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= FADR_ST_CMD;
      sh_q <= 32'h0;
      cnt_q <= 6'h0;
      alen_q <= `FADR_ALEN3;
      dum_q <= 4'h0;
      olw_q <= 4'h1;
      osrc_ext_q <= 1'b0;
      tgt_par_q <= 1'b0;
    end else if (cs_idle) begin
      st_q <= FADR_ST_CMD;
      cnt_q <= 6'h0;
    end else if (rise) begin
      case (st_q)
        FADR_ST_CMD: begin
          sh_q <= sh_n;
          cnt_q <= cnt_n;
          if (cmd_done) begin
            cnt_q <= 6'h0;
            osrc_ext_q <= 1'b0;
            olw_q <= four_wire_command_mode ? 4'h4 : 4'h1;
            alen_q <= ads_q ? `FADR_ALEN4 : `FADR_ALEN3;
            dum_q <= `FADR_DUMMY_SPI;
            st_q <= FADR_ST_SKIP;
            case (opc)
              `FADR_OP_RDEXT: begin
                osrc_ext_q <= 1'b1;
                st_q <= FADR_ST_OUT;
              end
              `FADR_OP_WREXT: begin
                tgt_par_q <= 1'b0;
                if (wel_q) begin
                  st_q <= FADR_ST_RIN;
                end
              end
              `FADR_OP_SETPAR: begin
                tgt_par_q <= 1'b1;
                if (four_wire_command_mode) begin
                  st_q <= FADR_ST_RIN;
                end
              end
              `FADR_OP_READ: begin
                dum_q <= 4'h0;
                if (!four_wire_command_mode && is_read) begin
                  st_q <= FADR_ST_ADDR;
                end
              end
              `FADR_OP_READ4: begin
                dum_q <= 4'h0;
                alen_q <= `FADR_ALEN4;
                if (!four_wire_command_mode && is_read) begin
                  st_q <= FADR_ST_ADDR;
                end
              end
              `FADR_OP_FAST: begin
                if (four_wire_command_mode) begin
                  dum_q <= {1'b0, par_q, 1'b0} + `FADR_DUMMY_QPI_MIN;
                end
                if (is_read) begin
                  st_q <= FADR_ST_ADDR;
                end
              end
              `FADR_OP_FAST4: begin
                alen_q <= `FADR_ALEN4;
                // Four-wire wrap burst is not served here
                if (!four_wire_command_mode && is_read) begin
                  st_q <= FADR_ST_ADDR;
                end
              end
              `FADR_OP_DUAL: begin
                olw_q <= 4'h2;
                if (!four_wire_command_mode && is_read) begin
                  st_q <= FADR_ST_ADDR;
                end
              end
              default: begin
                st_q <= FADR_ST_SKIP;
              end
            endcase
          end
        end
        FADR_ST_ADDR: begin
          sh_q <= sh_n;
          cnt_q <= cnt_n;
          if (addr_done) begin
            st_q <= (dum_q == 4'h0) ? FADR_ST_OUT : FADR_ST_DUMMY;
          end
        end
        FADR_ST_DUMMY: begin
          dum_q <= dum_q - 4'h1;
          if (dum_q == 4'h1) begin
            st_q <= FADR_ST_OUT;
          end
        end
        FADR_ST_RIN: begin
          sh_q <= sh_n;
          cnt_q <= cnt_n;
          if (rin_done) begin
            st_q <= FADR_ST_SKIP;
          end
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  // Mode flags, extended address byte and read parameters
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wel_q <= 1'b0;
      ads_q <= 1'b0;
      ext_q <= `FADR_EXT_RST;
      par_q <= `FADR_PAR_RST;
      rsten_q <= 1'b0;
    end else if (cmd_done) begin
      rsten_q <= 1'b0;
      case (opc)
        `FADR_OP_WREN: wel_q <= 1'b1;
        `FADR_OP_WRDI: wel_q <= 1'b0;
        `FADR_OP_EN4B: ads_q <= 1'b1;
        `FADR_OP_EX4B: ads_q <= 1'b0;
        `FADR_OP_RSTEN: rsten_q <= 1'b1;
        `FADR_OP_RST: begin
          // Soft reset only after the enable opcode
          if (rsten_q) begin
            wel_q <= 1'b0;
            ads_q <= 1'b0;
            ext_q <= `FADR_EXT_RST;
            par_q <= `FADR_PAR_RST;
          end
        end
        default: begin
          rsten_q <= 1'b0;
        end
      endcase
    end else if (rin_done) begin
      if (tgt_par_q) begin
        par_q <= sh_n[`FADR_PAR_LSB+1:`FADR_PAR_LSB];
      end else begin
        ext_q <= sh_n[7:0];
      end
    end else if (addr_done && ads_q) begin
      ext_q <= sh_n[31:24];
    end
  end

  assign src_byte = osrc_ext_q ? ext_q : fifo_out_data;
  assign cur_byte = (ocnt_q == 4'h0) ? src_byte : obyte_q;
  assign fifo_pop = fall && (st_q == FADR_ST_OUT) && (ocnt_q == 4'h0) && !osrc_ext_q
    && fifo_out_valid;

  // Output shifter, changes on sampled falling link edges
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_q <= 4'h0;
      oe_n_q <= 4'hF;
      obyte_q <= 8'h0;
      ocnt_q <= 4'h0;
    end else if (cs_idle || st_q != FADR_ST_OUT) begin
      // Lanes float during dummy clocks and between frames
      oe_n_q <= 4'hF;
      ocnt_q <= 4'h0;
    end else if (fall) begin
      obyte_q <= cur_byte << olw_q;
      ocnt_q <= ((ocnt_q == 4'h0) ? 4'h8 : ocnt_q) - olw_q;
      case (olw_q)
        4'h2: begin
          io_q <= {2'h0, cur_byte[7], cur_byte[6]};
          oe_n_q <= 4'hC;
        end
        4'h4: begin
          io_q <= cur_byte[7:4];
          oe_n_q <= 4'h0;
        end
        default: begin
          io_q <= {2'h0, cur_byte[7], 1'b0};
          oe_n_q <= 4'hD;
        end
      endcase
    end
  end

  // One array fetch outstanding; FIFO back-pressure stalls fetching
  assign issue = fact_q && !pend_q && fifo_in_ready && !cs_idle;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fact_q <= 1'b0;
      pend_q <= 1'b0;
      faddr_q <= 32'h0;
      areq_q <= '0;
    end else begin
      areq_q.rd <= issue;
      if (cs_idle) begin
        fact_q <= 1'b0;
      end else if (addr_done) begin
        fact_q <= 1'b1;
        faddr_q <= eff_addr;
      end else if (issue) begin
        areq_q.addr <= faddr_q;
        faddr_q <= faddr_q + 32'h1;
      end
      if (issue) begin
        pend_q <= 1'b1;
      end else if (arr_valid_i) begin
        pend_q <= 1'b0;
      end
    end
  end

  fadr_fifo #(
    .WIDTH(`FADR_BYTE_W),
    .DEPTH(`FADR_FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .flush_i(cs_idle),
    .in_valid_i(arr_valid_i && pend_q && fact_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(arr_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  assign io_o = io_q;
  assign io_oe_n_o = oe_n_q;
  assign write_arm_flag_o = wel_q;
  assign address_width_flag_o = ads_q;
  assign ext_addr_o = ext_q;
  assign arr_req_o = areq_q;
endmodule
`default_nettype wire

// ==== tb/fadr_arr_model.sv ====
// Array partner model answering each fetch one clock later
`timescale 1ns/1ns
`default_nettype none
module fadr_arr_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire fadr_pkg::fadr_arr_req_t req_i,
  output logic valid_o,
  output logic [7:0] data_o
);
  import fadr_pkg::*;
  // Content mixes top and bottom address bytes so bits 31..24 show up
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_o <= 1'h0;
      data_o <= 8'h00;
    end else begin
      valid_o <= req_i.rd;
      data_o <= req_i.rd ? (req_i.addr[7:0] ^ req_i.addr[31:24]) : ~data_o; // Stale data flips
    end
  end
endmodule
`default_nettype wire

// ==== tb/fadr_top_chk.sv ====
// Port checker of the flash read path
`timescale 1ns/1ns
`default_nettype none
module fadr_top_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic busy_i,
  input wire logic [3:0] io_oe_n_o,
  input wire logic write_arm_flag_o,
  input wire logic address_width_flag_o,
  input wire logic [7:0] ext_addr_o,
  input wire fadr_pkg::fadr_arr_req_t arr_req_o
);
  import fadr_pkg::*;
  logic busy_frame_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Busy seen from frame start on; drops once busy falls, since decode samples it late
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_frame_q <= 1'h0;
    end else if (cs_n_i) begin
      busy_frame_q <= busy_i;
    end else begin
      busy_frame_q <= busy_frame_q && busy_i;
    end
  end
  property p_rst_vals;
    $rose(nrst_i) |-> ext_addr_o == 8'h00 && !write_arm_flag_o && !address_width_flag_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("state not clear after reset");
  property p_fetch_idle;
    cs_n_i [*8] |-> !arr_req_o.rd;
  endproperty
  a_fetch_idle: assert property (p_fetch_idle) else $error("fetch outside frame");
  property p_lanes_idle;
    cs_n_i [*5] |-> io_oe_n_o == 4'hF;
  endproperty
  a_lanes_idle: assert property (p_lanes_idle) else $error("lanes driven after frame");
  property p_busy_quiet;
    busy_frame_q && !cs_n_i |-> !arr_req_o.rd && io_oe_n_o == 4'hF;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("read served while busy");
  property p_arm_in_frame;
    $rose(write_arm_flag_o) |-> !$past(cs_n_i, 3);
  endproperty
  a_arm_in_frame: assert property (p_arm_in_frame) else $error("arm set outside frame");
  property p_width_in_frame;
    $changed(address_width_flag_o) |-> !$past(cs_n_i, 3);
  endproperty
  a_width_in_frame: assert property (p_width_in_frame) else $error("width flag moved");
  property p_ext_cause;
    $changed(ext_addr_o) |-> ext_addr_o == 8'h00 || $past(write_arm_flag_o)
      || $past(address_width_flag_o);
  endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("ext byte written unarmed");
  property p_dual_lanes;
    !io_oe_n_o[0] |-> !io_oe_n_o[1];
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) else $error("lane one idle beside lane zero");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the flash read path
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import fadr_pkg::*;
  logic clock_i = 1'h0, nrst_i = 1'h0, sclk = 1'h0, cs_n = 1'h1, busy = 1'h0, fw = 1'h0;
  logic av, wa, aw;
  logic [3:0] io_in = 4'h0, io_o, oe_n, seen_oe;
  logic [7:0] ext, dat_i;
  logic [7:0] rf [4] = '{8'h03, 8'h13, 8'h0C, 8'h3B};
  logic [63:0] tx, rx;
  fadr_arr_req_t req;
  int n_mismatch = 0;
  int checks_done = 0;
  // 10 MHz system clock
  always #50 clock_i = ~clock_i;
  fadr_top uut (.clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(io_in), .io_o(io_o), .io_oe_n_o(oe_n), .four_wire_command_mode_i(fw),
    .busy_i(busy), .write_arm_flag_o(wa), .address_width_flag_o(aw), .ext_addr_o(ext),
    .arr_req_o(req), .arr_valid_i(av), .arr_data_i(dat_i));
  fadr_arr_model arr (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req), .valid_o(av),
    .data_o(dat_i));
  function automatic logic [7:0] dat(input logic [31:0] a);
    return a[7:0] ^ a[31:24];
  endfunction
  task automatic conclude();
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Link clocks of 800 ns; wi 0 means host lanes toggle as filler, wo lanes collected
  task automatic run(input int n, input int wi, input int wo);
    for (int i = 0; i < n; i++) begin
      if (wi == 0) io_in <= ~io_in;
      else if (wi == 4) io_in <= tx[63:60];
      else io_in <= {3'h0, tx[63]};
      if (wi > 0) tx = tx << wi;
      repeat (4) @(posedge clock_i);
      seen_oe = seen_oe & oe_n;
      rx = (rx << wo) | (wo == 4 ? io_o : wo == 2 ? io_o[1:0] : io_o[1]);
      sclk <= 1'h1;
      repeat (4) @(posedge clock_i);
      sclk <= 1'h0;
    end
  endtask
  // Opens a frame: opcode, ab address bits, dm dummy clocks, w command lanes
  task automatic hdr(input logic [7:0] op, input logic [31:0] a, input int ab, input int dm,
    input int w);
    seen_oe = 4'hF;
    cs_n <= 1'h0;
    repeat (4) @(posedge clock_i);
    tx = {op, 56'h0};
    run(8 / w, w, 1);
    tx = {a << (32 - ab), 32'h0};
    if (ab > 0) run(ab / w, w, 1);
    run(dm, 0, 1);
  endtask
  // Gap after a frame just as long as the longest idle rule window (8 clocks)
  task automatic fin();
    cs_n <= 1'h1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic cmd(input logic [7:0] op, input int w);
    hdr(op, 32'h0, 0, 0, w);
    fin();
  endtask
  task automatic wext(input logic [7:0] v);
    hdr(8'hC5, 32'h0, 0, 0, 1);
    tx = {v, 56'h0};
    run(8, 1, 1);
    fin();
  endtask
  task automatic rdc(input logic [7:0] e);
    hdr(8'hC8, 32'h0, 0, 0, 1);
    repeat (2) begin
      run(8, 0, 1);
      `CHK("ext read", e, rx[7:0])
    end
    fin();
  endtask
  // Streams nb bytes from ea onward; ps pauses the host after the second byte
  task automatic rdchk(input logic [7:0] op, input logic [31:0] a, input int ab, input int dm,
    input int w, input int wo, input logic [31:0] ea, input int nb, input int ps);
    hdr(op, a, ab, dm, w);
    for (int i = 0; i < nb; i++) begin
      run(8 / wo, 0, wo);
      `CHK("read byte", dat(ea + i), rx[7:0])
      if (i == 1) repeat (ps) @(posedge clock_i);
    end
    fin();
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clock_i);
    n_mismatch++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    `CHK("reset state", 14'h3C00, {oe_n, wa, aw, ext})
    rdc(8'h00);
    wext(8'hAA);
    `CHK("ext unarmed", 8'h00, ext)
    cmd(8'h06, 1);
    `CHK("write arm", 1'h1, wa)
    wext(8'h81);
    `CHK("ext armed", 8'h81, ext)
    rdc(8'h81);
    rdchk(8'h03, 32'hFE, 24, 0, 1, 1, 32'h810000FE, 40, 400);
    rdchk(8'h13, 32'h12345678, 32, 0, 1, 1, 32'h12345678, 2, 0);
    `CHK("ext kept", 8'h81, ext)
    rdchk(8'h0B, 32'h300, 24, 8, 1, 1, 32'h81000300, 2, 0);
    rdchk(8'h0C, 32'hAB000001, 32, 8, 1, 1, 32'hAB000001, 2, 0);
    rdchk(8'h3B, 32'h400, 24, 8, 1, 2, 32'h81000400, 3, 0);
    busy <= 1'h1;
    @(posedge clock_i);
    hdr(8'h03, 32'h0, 24, 0, 1);
    run(16, 0, 1);
    fin();
    busy <= 1'h0;
    `CHK("busy lanes", 4'hF, seen_oe)
    fw <= 1'h1;
    for (int f = 0; f < 4; f++) begin
      if (f > 0) begin
        hdr(8'hC0, 32'h0, 0, 0, 4);
        tx = {2'h0, 2'(f), 60'h0};
        run(2, 4, 4);
        fin();
      end
      rdchk(8'h0B, 32'h20 + f, 24, 2 * f + 2, 4, 4, 32'h81000020 + f, 2, 0);
    end
    foreach (rf[i]) begin
      hdr(rf[i], 32'h0, 24, 8, 4);
      run(8, 0, 4);
      fin();
      `CHK("refused lanes", 4'hF, seen_oe)
    end
    fw <= 1'h0;
    cmd(8'hB7, 1);
    `CHK("four byte mode", 1'h1, aw)
    rdchk(8'h03, 32'h7F000010, 32, 0, 1, 1, 32'h7F000010, 1, 0);
    `CHK("ext from address", 8'h7F, ext)
    cmd(8'hE9, 1);
    `CHK("three byte mode", 1'h0, aw)
    rdc(8'h7F);
    rdchk(8'h03, 32'h10, 24, 0, 1, 1, 32'h7F000010, 1, 0);
    // Reset enable cancelled by an opcode in between, then a real soft reset
    cmd(8'hB7, 1);
    cmd(8'h66, 1);
    cmd(8'h06, 1);
    cmd(8'h99, 1);
    `CHK("reset cancelled", 10'h37F, {wa, aw, ext})
    cmd(8'h66, 1);
    cmd(8'h99, 1);
    `CHK("soft reset", 10'h000, {wa, aw, ext})
    fw <= 1'h1;
    rdchk(8'h0B, 32'h30, 24, 2, 4, 4, 32'h00000030, 1, 0);
    fw <= 1'h0;
    // Disarmed writes must not reach the extended byte
    cmd(8'h06, 1);
    wext(8'h5A);
    cmd(8'h04, 1);
    wext(8'h11);
    `CHK("write disarmed", 9'h05A, {wa, ext})
    // Hardware reset in mid-run clears the volatile byte again
    nrst_i <= 1'h0;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    `CHK("reset again", 14'h3C00, {oe_n, wa, aw, ext})
    rdc(8'h00);
    conclude();
  end
endmodule
bind fadr_top fadr_top_chk chk (.clock_i(clock_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
  .busy_i(busy_i), .io_oe_n_o(io_oe_n_o), .write_arm_flag_o(write_arm_flag_o),
  .address_width_flag_o(address_width_flag_o), .ext_addr_o(ext_addr_o),
  .arr_req_o(arr_req_o));
`default_nettype wire
